// ===== drs_pkg.sv
// Shared constants and types for the display reset sequencer.
// Assumes a single 20 MHz reference clock.
`default_nettype none
package drs_pkg;

    // -------------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------------
    localparam int CLK_MHZ        = 20;
    localparam int CLK_KHZ        = 20000;
    localparam int REJECT_US      = 5;    // Shorter low pulses are ignored.
    localparam int VALID_US       = 9;    // Longer low pulses always reset.
    localparam int PULSE_MIN_US   = 10;   // Least hold time asked of host.
    localparam int LOAD_MAX_MS    = 5;    // Release interval from sleep.
    localparam int ACTIVE_MAX_MS  = 120;  // Release interval from active.
    localparam int CMD_WAIT_MS    = 5;    // Host wait before commands.
    localparam int WAKE_WAIT_MS   = 120;  // Host wait before wake command.
    localparam int REJECT_CYC     = REJECT_US * CLK_MHZ;
    localparam int VALID_CYC      = VALID_US * CLK_MHZ;
    localparam int LOW_ACCEPT_CYC = (REJECT_US + VALID_US) * CLK_MHZ / 2;
    localparam int LOAD_MAX_CYC   = LOAD_MAX_MS * CLK_KHZ;
    localparam int ACTIVE_MAX_CYC = ACTIVE_MAX_MS * CLK_KHZ;
    localparam int BLANK_CYC      = ACTIVE_MAX_CYC - LOAD_MAX_CYC;

    // -------------------------------------------------------------------
    // Widths, storage layout and defaults
    // -------------------------------------------------------------------
    localparam int FILT_W    = 8;
    localparam int TMR_W     = 22;
    localparam int IDX_W     = 3;
    localparam int NVM_WORDS = 5;
    localparam logic [IDX_W-1:0] IDX_ID0  = 3'h0;
    localparam logic [IDX_W-1:0] IDX_ID1  = 3'h1;
    localparam logic [IDX_W-1:0] IDX_ID2  = 3'h2;
    localparam logic [IDX_W-1:0] IDX_COMMON_ELECTRODE_SETTING = 3'h3;
    localparam logic [IDX_W-1:0] IDX_MISC = 3'h4;
    localparam logic [7:0] DEF_ID   = 8'h00;
    localparam logic [7:0] DEF_COMMON_ELECTRODE_SETTING = 8'h00;
    localparam logic [7:0] DEF_MISC = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_HELD  = 3'b001,
        ST_BLANK = 3'b010,
        ST_LOAD  = 3'b011,
        ST_DONE  = 3'b100
    } drs_state_e;

    typedef struct packed {
        logic [7:0] id0;
        logic [7:0] id1;
        logic [7:0] id2;
        logic [7:0] common_electrode_setting;
        logic [7:0] misc;
    } drs_settings_s;

    typedef struct packed {
        logic              level;
        logic [FILT_W-1:0] cnt;
    } drs_filt_s;

    typedef struct packed {
        drs_state_e        st;
        logic              from_active;
        logic [TMR_W-1:0]  tmr;
        logic [TMR_W-1:0]  ldt;
        logic [IDX_W-1:0]  idx;
        logic              rd_en;
        drs_settings_s     set;
        logic              blank;
        logic              defaults;
        logic              fault;
    } drs_main_s;

endpackage : drs_pkg
`default_nettype wire

// ===== drs_glitch_filter.sv
// Glitch filter for the active-low reset pin.
// Assumes the pin is already synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module drs_glitch_filter
    import drs_pkg::*;
#(
    parameter int LOW_CYC  = LOW_ACCEPT_CYC,
    parameter int HIGH_CYC = REJECT_CYC
) (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic reset_pin_active_low,
    output logic      rst_low
);

    // -------------------------------------------------------------------
    // Filter state
    // -------------------------------------------------------------------
    drs_filt_s f_reg;
    drs_filt_s f_next;

    // A change is taken only after it has stood for the full count, so a
    // short spike in either direction never reaches the sequencer.
    always_comb begin
        f_next = f_reg;
        if (reset_pin_active_low == f_reg.level) begin
            f_next.cnt = '0;
        end else if (f_reg.level) begin
            if (f_reg.cnt == FILT_W'(LOW_CYC - 1)) begin
                f_next.level = 1'b0;
                f_next.cnt   = '0;
            end else begin
                f_next.cnt = f_reg.cnt + 1'b1;
            end
        end else begin
            if (f_reg.cnt == FILT_W'(HIGH_CYC - 1)) begin
                f_next.level = 1'b1;
                f_next.cnt   = '0;
            end else begin
                f_next.cnt = f_reg.cnt + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            f_reg <= '{level: 1'b1, cnt: '0};
        end else begin
            f_reg <= f_next;
        end
    end

    assign rst_low = ~f_reg.level;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    // Run lengths of the raw pin, saturating, read only by the checks.
    logic [8:0] low_run_reg;
    logic [8:0] high_run_reg;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            low_run_reg  <= '0;
            high_run_reg <= '0;
        end else begin
            low_run_reg  <= reset_pin_active_low ? 9'h000 :
                            (&low_run_reg ? low_run_reg : low_run_reg + 1'b1);
            high_run_reg <= !reset_pin_active_low ? 9'h000 :
                           (&high_run_reg ? high_run_reg : high_run_reg + 1'b1);
        end
    end

    short_reject_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(f_reg.level) |-> low_run_reg >= 9'(LOW_CYC))
        else $error("Reset taken from a too short low pulse.");
    long_accept_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        low_run_reg >= 9'(VALID_CYC) |-> rst_low)
        else $error("Long low pulse did not reset.");
    spike_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(f_reg.level) |-> high_run_reg >= 9'(HIGH_CYC))
        else $error("High spike ended a held reset.");
    spike_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        f_reg.level && low_run_reg == 9'h032 ##1 reset_pin_active_low);

endmodule : drs_glitch_filter
`default_nettype wire

// ===== drs_sequencer.sv
// Display reset sequencer: filters the reset pin, blanks the panel, reloads
// identification and common electrode settings, then restores defaults.
// Assumes a synchronous reset pin, a simple word-read storage port and a
// core that reports whether the display is in its active state.
//
// Overview of operation
// - Pulses under 5 us ignored, over 9 us reset.
// - Short high spikes cannot end held reset.
// - A release from sleep reloads stored settings within 5 ms.
// - Release done in 5 ms sleeping, 120 active.
// - Panel blanked during reset; blank sequence from active.
// - Completion restores all hardware reset defaults.
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer
    import drs_pkg::*;
#(
    parameter int LOAD_CYC_MAX = LOAD_MAX_CYC,
    parameter int BLANK_CYCLES = BLANK_CYC
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             reset_pin_active_low,
    input  wire logic             display_active,
    input  wire logic             host_cmd_valid,
    output logic                  core_cmd_valid,
    output logic                  ready,
    output logic                  panel_blank,
    output logic                  apply_defaults,
    output logic                  nvm_rd_en,
    output logic [IDX_W-1:0]      nvm_addr,
    input  wire logic [7:0]       nvm_rd_data,
    input  wire logic             nvm_rd_valid,
    output logic                  nvm_fault,
    output drs_settings_s         settings
);

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Places one stored byte into the settings image by its index.
    function automatic drs_settings_s put_word(input drs_settings_s s,
                                               input logic [IDX_W-1:0] i,
                                               input logic [7:0] d);
        drs_settings_s r;
        r = s;
        unique case (i)
            IDX_ID0:  r.id0 = d;
            IDX_ID1:  r.id1 = d;
            IDX_ID2:  r.id2 = d;
            IDX_COMMON_ELECTRODE_SETTING: r.common_electrode_setting = d;
            IDX_MISC: r.misc = d;
            default:  r = s;
        endcase
        return r;
    endfunction : put_word

    // Saturating timer step, so a long hold cannot wrap the blank timer.
    function automatic logic [TMR_W-1:0] tick(input logic [TMR_W-1:0] t);
        return (&t) ? t : t + 1'b1;
    endfunction : tick

    localparam drs_settings_s SET_DEF = '{id0: DEF_ID, id1: DEF_ID,
        id2: DEF_ID, common_electrode_setting: DEF_COMMON_ELECTRODE_SETTING, misc: DEF_MISC};

    // The pin filter holds a release back by its high count, so the reload
    // gives that time up and the interval still ends in time counted from
    // the pin. LOAD_CYC_MAX must stay well above the filter's high count.
    localparam int LOAD_LIMIT = LOAD_CYC_MAX - REJECT_CYC - 4;

    // -------------------------------------------------------------------
    // Pin filter
    // -------------------------------------------------------------------
    logic rst_low;

    drs_glitch_filter #(
        .LOW_CYC  (LOW_ACCEPT_CYC),
        .HIGH_CYC (REJECT_CYC)
    ) drs_glitch_filter_i (
        .ref_clk              (ref_clk),
        .nrst                 (nrst),
        .reset_pin_active_low (reset_pin_active_low),
        .rst_low              (rst_low)
    );

    // -------------------------------------------------------------------
    // Sequencer state
    // -------------------------------------------------------------------
    drs_main_s m_reg;
    drs_main_s m_next;

    // Next state. A new filtered reset in any phase restarts the sequence,
    // since a half-finished reload must not be trusted.
    always_comb begin
        m_next          = m_reg;
        m_next.defaults = 1'b0;
        unique case (m_reg.st)
            ST_RUN: begin
                if (rst_low) begin
                    m_next.st          = ST_HELD;
                    m_next.from_active = display_active;
                    m_next.tmr         = '0;
                    m_next.blank       = 1'b1;
                end
            end
            ST_HELD: begin
                m_next.tmr = tick(m_reg.tmr);
                if (!rst_low) begin
                    m_next.st    = m_reg.from_active ? ST_BLANK : ST_LOAD;
                    m_next.ldt   = '0;
                    m_next.idx   = '0;
                    m_next.set   = SET_DEF;
                    m_next.fault = 1'b0;
                    m_next.rd_en = !m_reg.from_active;
                end
            end
            ST_BLANK: begin
                // Blanking runs from the start of reset; the rest of the
                // budget is left for the reload.
                m_next.tmr = tick(m_reg.tmr);
                if (rst_low) begin
                    m_next.st  = ST_HELD;
                    m_next.tmr = '0;
                end else if (m_reg.tmr >= TMR_W'(BLANK_CYCLES - 1)) begin
                    m_next.st    = ST_LOAD;
                    m_next.rd_en = 1'b1;
                end
            end
            ST_LOAD: begin
                m_next.ldt = tick(m_reg.ldt);
                if (rst_low) begin
                    m_next.st    = ST_HELD;
                    m_next.tmr   = '0;
                    m_next.rd_en = 1'b0;
                end else if (nvm_rd_valid) begin
                    m_next.set = put_word(m_reg.set, m_reg.idx, nvm_rd_data);
                    if (m_reg.idx == IDX_W'(NVM_WORDS - 1)) begin
                        m_next.st    = ST_DONE;
                        m_next.rd_en = 1'b0;
                    end else begin
                        m_next.idx = m_reg.idx + 1'b1;
                    end
                end else if (m_reg.ldt >= TMR_W'(LOAD_LIMIT)) begin
                    // A silent store must not stall the release; the
                    // defaults stay in place and the fault is reported.
                    m_next.st    = ST_DONE;
                    m_next.rd_en = 1'b0;
                    m_next.fault = 1'b1;
                end
            end
            ST_DONE: begin
                m_next.st       = ST_RUN;
                m_next.defaults = 1'b1;
                m_next.blank    = 1'b0;
            end
            default: begin
                m_next.st = ST_HELD;
            end
        endcase
    end

    // State register. Power-on starts with a reload from the low-power state.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            m_reg <= '{st: ST_LOAD, from_active: 1'b0, tmr: '0, ldt: '0,
                       idx: '0, rd_en: 1'b1, set: SET_DEF, blank: 1'b1,
                       defaults: 1'b0, fault: 1'b0};
        end else begin
            m_reg <= m_next;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // Commands pass only in the run state and not in the cycle a reset is
    // first seen, so nothing slips through during the release interval.
    assign ready          = (m_reg.st == ST_RUN);
    assign core_cmd_valid = host_cmd_valid & ready & ~rst_low;
    assign panel_blank    = m_reg.blank;
    assign apply_defaults = m_reg.defaults;
    assign nvm_rd_en      = m_reg.rd_en;
    assign nvm_addr       = m_reg.idx;
    assign nvm_fault      = m_reg.fault;
    assign settings       = m_reg.set;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    // Cycles since filtered release, read only by the checks.
    logic [TMR_W-1:0] rel_cnt_reg;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rel_cnt_reg <= '0;
        end else if (m_reg.st == ST_RUN || m_reg.st == ST_HELD) begin
            rel_cnt_reg <= '0;
        end else begin
            rel_cnt_reg <= tick(rel_cnt_reg);
        end
    end

    blank_hold_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        m_reg.st != ST_RUN |-> panel_blank)
        else $error("Panel not blanked during reset.");
    reset_entry_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ready && rst_low |=> m_reg.st == ST_HELD && panel_blank)
        else $error("Filtered reset did not start the sequence.");
    cmd_block_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        rst_low |=> !core_cmd_valid)
        else $error("Command passed during reset.");
    reload_start_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        m_reg.st == ST_HELD && !rst_low && !m_reg.from_active
        |=> nvm_rd_en && nvm_addr == 3'h0)
        else $error("Release did not start the reload.");
    sleep_release_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !ready && m_reg.st != ST_HELD && !m_reg.from_active
        |-> rel_cnt_reg < TMR_W'(LOAD_CYC_MAX - REJECT_CYC))
        else $error("Release from sleep exceeded its limit.");
    active_release_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !ready && m_reg.st != ST_HELD
        |-> rel_cnt_reg < TMR_W'(BLANK_CYCLES + LOAD_CYC_MAX))
        else $error("Release from active exceeded its limit.");
    defaults_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        $rose(ready) |-> apply_defaults && !panel_blank)
        else $error("Defaults not applied on completion.");
    cover_sleep_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        m_reg.st == ST_HELD && !m_reg.from_active ##1 m_reg.st == ST_LOAD);
    cover_active_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        m_reg.st == ST_BLANK ##1 m_reg.st == ST_LOAD);
    cover_fault_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        $rose(nvm_fault));

endmodule : drs_sequencer
`default_nettype wire

// ===== drs_nvm_model.sv
// Behavioural model of the settings storage behind the reset sequencer.
// Assumes word reads qualified by nvm_rd_en and answered on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module drs_nvm_model
    import drs_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             nvm_rd_en,
    input  wire logic [IDX_W-1:0] nvm_addr,
    input  wire drs_settings_s    contents,
    input  wire logic [3:0]       delay_cyc,
    input  wire logic             mute,
    output logic [7:0]            nvm_rd_data,
    output logic                  nvm_rd_valid
);
    logic [3:0] wait_cnt;
    logic       gap;
    logic       fire;

    // Start quiet so the first edge sees a defined strobe.
    initial begin
        wait_cnt = 4'h0;
        gap = 1'b0;
        nvm_rd_valid = 1'b0;
        nvm_rd_data = 8'h5A;
    end

    // A word is answered after delay_cyc idle cycles; mute models a dead part.
    assign fire = nvm_rd_en && !mute && !gap && (wait_cnt >= delay_cyc);

    // The gap cycle lets the address move on before the next answer, and the
    // data lines toggle between answers so no stale byte can pass for data.
    always @(posedge ref_clk) begin
        nvm_rd_valid <= fire;
        nvm_rd_data  <= fire ? contents[39 - 8 * int'(nvm_addr) -: 8]
                             : ~nvm_rd_data;
        gap          <= fire;
        if (!nvm_rd_en || mute || fire || gap) begin
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : drs_nvm_model
`default_nettype wire

// ===== test_display_reset_sequencer.sv
// Self-checking bench for the display reset sequencer.
// Assumes drs_nvm_model as storage and scaled-down release timers.
`timescale 1ns/1ps
`default_nettype none
module test_display_reset_sequencer
    import drs_pkg::*;
();
    localparam int LCYC = 200;  // Scaled limit, above the filter delay.
    localparam int BCYC = 400;  // Scaled blanking time.

    logic             ref_clk = 1'b0;
    logic             nrst = 1'b0;
    logic             reset_pin_active_low = 1'b1;
    logic             display_active = 1'b0;
    logic             host_cmd_valid = 1'b0;
    logic             mute = 1'b0;
    logic [3:0]       delay_cyc = 4'h1;
    drs_settings_s    contents = '0;
    logic             core_cmd_valid;
    logic             ready;
    logic             panel_blank;
    logic             apply_defaults;
    logic             nvm_rd_en;
    logic [IDX_W-1:0] nvm_addr;
    logic [7:0]       nvm_rd_data;
    logic             nvm_rd_valid;
    logic             nvm_fault;
    drs_settings_s    settings;
    int               seed = 7;
    int               n_mismatch = 0;
    int               comparisons = 0;
    int               cnt;
    int               short_len[5];
    logic [41:0]      expq[$];
    logic [41:0]      note;

    drs_sequencer #(.LOAD_CYC_MAX(LCYC), .BLANK_CYCLES(BCYC)) drs_sequencer_i (
        .ref_clk              (ref_clk),
        .nrst                 (nrst),
        .reset_pin_active_low (reset_pin_active_low),
        .display_active       (display_active),
        .host_cmd_valid       (host_cmd_valid),
        .core_cmd_valid       (core_cmd_valid),
        .ready                (ready),
        .panel_blank          (panel_blank),
        .apply_defaults       (apply_defaults),
        .nvm_rd_en            (nvm_rd_en),
        .nvm_addr             (nvm_addr),
        .nvm_rd_data          (nvm_rd_data),
        .nvm_rd_valid         (nvm_rd_valid),
        .nvm_fault            (nvm_fault),
        .settings             (settings)
    );

    drs_nvm_model drs_nvm_model_i (
        .ref_clk      (ref_clk),
        .nvm_rd_en    (nvm_rd_en),
        .nvm_addr     (nvm_addr),
        .contents     (contents),
        .delay_cyc    (delay_cyc),
        .mute         (mute),
        .nvm_rd_data  (nvm_rd_data),
        .nvm_rd_valid (nvm_rd_valid)
    );

    // 20 MHz reference clock.
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    // Leftover notes mean a completion never showed up.
    task automatic final_report();
        chk(expq.size(), 0);
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // New storage image; the note says whether the reload should succeed.
    task automatic expect_load(input logic ok);
        logic [39:0] v;
        v = 40'({$random(seed), $random(seed)});
        contents <= v;
        expq.push_back({ok, ~ok, v});
    endtask : expect_load

    // Mode 1 expects a held reset, mode 2 expects normal running.
    task automatic drive_pin(input logic v, input int n, input int mode);
        repeat (n) begin
            @(posedge ref_clk);
            reset_pin_active_low <= v;
            if (mode == 1) begin
                chk(ready, 1'b0);
                chk(nvm_rd_en, 1'b0);
                chk(panel_blank, 1'b1);
            end
            if (mode == 2) chk(ready, 1'b1);
        end
    endtask : drive_pin

    // Bounded wait for ready; traffic must be dropped and the panel blank.
    task automatic wait_ready(input int bound);
        cnt = 0;
        do begin
            @(posedge ref_clk);
            cnt++;
            if (ready !== 1'b1) begin
                chk(core_cmd_valid, 1'b0);
                chk(panel_blank, 1'b1);
            end
            if (cnt > bound) begin
                chk(cnt, bound);
                final_report();
            end
        end while (ready !== 1'b1);
    endtask : wait_ready

    // Each completion pulse takes the oldest note and checks the reload.
    always @(posedge ref_clk) begin
        if (apply_defaults === 1'b1) begin
            if (expq.size() == 0) begin
                chk(1'b1, 1'b0);
            end else begin
                note = expq.pop_front();
                chk(nvm_fault, note[40]);
                chk(settings, note[41] ? note[39:0] :
                    {DEF_ID, DEF_ID, DEF_ID, DEF_COMMON_ELECTRODE_SETTING, DEF_MISC});
            end
        end
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (20000) @(posedge ref_clk);
        chk(1'b0, 1'b1);
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        @(posedge ref_clk);
        expect_load(1'b1);
        repeat (7) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_ready(LCYC + 20);
        repeat (LCYC) @(posedge ref_clk);
        host_cmd_valid <= 1'b1;
        @(posedge ref_clk);
        chk(core_cmd_valid, 1'b1);
        chk(panel_blank, 1'b0);
        // Short pulses, including the longest one still rejected.
        short_len = '{1, 50, 99, 139, 1 + ($unsigned($random(seed)) % 139)};
        foreach (short_len[i]) begin
            drive_pin(1'b0, short_len[i], 2);
            drive_pin(1'b1, 120, 2);
        end
        // Reset from sleep with a high spike inside the held pulse.
        delay_cyc <= 4'h0;
        expect_load(1'b1);
        drive_pin(1'b0, 200, 0);
        drive_pin(1'b1, 60, 1);
        drive_pin(1'b0, 60, 1);
        drive_pin(1'b1, 1, 1);
        wait_ready(LCYC + 150);
        chk(cnt <= LCYC + 1, 1'b1);
        // Silent storage: the interval still ends, flagged as a fault.
        mute <= 1'b1;
        expect_load(1'b0);
        drive_pin(1'b0, 200, 0);
        drive_pin(1'b1, 1, 1);
        wait_ready(LCYC + 150);
        chk(cnt <= LCYC + 1, 1'b1);
        // Reset from the active state runs the full blanking first.
        mute <= 1'b0;
        display_active <= 1'b1;
        expect_load(1'b1);
        drive_pin(1'b0, 200, 0);
        drive_pin(1'b1, 1, 1);
        wait_ready(BCYC + LCYC + 150);
        chk(cnt > BCYC - 100, 1'b1);
        chk(cnt <= BCYC + LCYC + 20, 1'b1);
        display_active <= 1'b0;
        repeat (LCYC) @(posedge ref_clk);
        chk(core_cmd_valid, 1'b1);
        final_report();
    end
endmodule : test_display_reset_sequencer
`default_nettype wire
